/* File: src/ifs_sequencer.sv */
// control sequencer of the indicator flasher switch
// What this block does
// - output held low past init time starts time base, lamp on
// - first diagnosis instant after turn-on measures load current
// - underload switches off at once, then flashes at failure period
// - normal load keeps channel on and normal period
// - on-time to period ratio fixed in every flashing mode
// - short circuit at measurement latches the device off
// - sense below reference raises fault doubling flash frequency
// - charge stops at high threshold, restarts at low threshold
// - large init charge current first, controlled currents afterwards
// - supply-to-output below minimum keeps device inactive
// - low output impedance activates switch, high stays sensing
// - absolute or dynamic temperature trip switches channel off
// - after protective off, stay off until temperature acceptable
// - restart after cool-down only within first diagnosis window
// - restart conditions past window latch off until output high
// - sense sampled once per diagnosis instant, only without hard failure
// - supply measurement pulsed in the same cycle as each switch-on
module ifs_sequencer
  import ifs_pkg::*;
#(
  parameter int unsigned INIT_COUNT = INIT_CYCLES,
  parameter int unsigned RESTART_COUNT = RESTART_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire ifs_pkg::ifs_sense_t sense_in,
  output ifs_pkg::ifs_ctrl_t ctrl_out,
  output ifs_pkg::ifs_state_t state_out
);
  import ifs_pkg::*;

  typedef struct packed {
    ifs_state_t state;
    ifs_ctrl_t ctrl;
    logic [31:0] init_cnt;
    logic [31:0] win_cnt;
    logic in_window;
    logic first_diag;
    logic fail;
    logic [1:0] halves;
    logic cap_high_d;
    logic cap_low_d;
    logic out_low_d;
  } ifs_seq_state_t;

  ifs_sense_t s;
  ifs_seq_state_t st_reg;
  ifs_seq_state_t st_next;
  logic hot;
  logic hard_fail;
  logic hi_rise;
  logic lo_rise;
  logic out_rise;
  logic [1:0] half_target;

  ifs_sync #(
    .WIDTH($bits(ifs_sense_t))
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .async_in(sense_in),
    .sync_out(s)
  );

  assign hot = s.absolute_temp_trip | s.dynamic_temp_trip;
  assign hard_fail = hot | s.current_limit;
  assign hi_rise = s.cap_high & ~st_reg.cap_high_d;
  assign lo_rise = s.cap_low & ~st_reg.cap_low_d;
  assign out_rise = ~s.out_low & st_reg.out_low_d;
  // failure mode needs half the threshold crossings per phase: double frequency
  assign half_target = st_reg.fail ? PHASE_FAIL_HALVES : PHASE_NORM_HALVES;

  always_comb begin
    st_next = st_reg;
    st_next.cap_high_d = s.cap_high;
    st_next.cap_low_d = s.cap_low;
    st_next.out_low_d = s.out_low;
    st_next.ctrl.sense_sample = 1'b0;
    st_next.ctrl.supply_measure = 1'b0;
    if (st_reg.in_window && st_reg.win_cnt != '0) begin
      st_next.win_cnt = st_reg.win_cnt - 32'h1;
    end
    // charge pump follows the two thresholds in the flashing and thermal states; idle, init and latched override it
    if (s.cap_high) begin
      st_next.ctrl.charge = IFS_CHG_UNLOAD;
    end else if (s.cap_low) begin
      st_next.ctrl.charge = IFS_CHG_LOAD;
    end
    case (st_reg.state)
      IFS_IDLE: begin
        st_next.ctrl = '0;
        st_next.init_cnt = '0;
        st_next.fail = 1'b0;
        st_next.in_window = 1'b0;
        // leak_low means the estimated output impedance is below the leak limit
        if (s.out_low && s.supply_ok && s.leak_low) begin
          st_next.state = IFS_INIT;
          st_next.ctrl.charge = IFS_CHG_INIT;
        end
      end
      IFS_INIT: begin
        st_next.ctrl.charge = IFS_CHG_INIT;
        if (!s.out_low || !s.supply_ok || !s.leak_low) begin
          st_next.state = IFS_IDLE;
          st_next.ctrl.charge = IFS_CHG_NONE;
        end else if (st_reg.init_cnt >= 32'(INIT_COUNT - 1)) begin
          st_next.state = IFS_FLASH_ON;
          st_next.ctrl.channel_on = 1'b1;
          st_next.ctrl.supply_measure = 1'b1;
          st_next.ctrl.charge = IFS_CHG_UNLOAD;
          st_next.first_diag = 1'b1;
          st_next.halves = '0;
          st_next.in_window = 1'b1;
          st_next.win_cnt = 32'(RESTART_COUNT);
        end else begin
          st_next.init_cnt = st_reg.init_cnt + 32'h1;
        end
      end
      IFS_FLASH_ON: begin
        if (hot) begin
          st_next.state = IFS_THERMAL;
          st_next.ctrl.channel_on = 1'b0;
        end else if (lo_rise) begin
          if (st_reg.first_diag) begin
            st_next.first_diag = 1'b0;
            // hard failure makes the sense meaningless, so skip sampling
            st_next.ctrl.sense_sample = ~hard_fail;
            st_next.in_window = 1'b0;
            if (hard_fail) begin
              st_next.halves = st_reg.halves;
            end else if (s.short_circuit) begin
              st_next.state = IFS_LATCHED;
              st_next.ctrl.channel_on = 1'b0;
              st_next.ctrl.latched = 1'b1;
            end else if (s.sense_low) begin
              st_next.fail = 1'b1;
              st_next.ctrl.failure_mode = 1'b1;
              st_next.state = IFS_FLASH_OFF;
              st_next.ctrl.channel_on = 1'b0;
              st_next.halves = '0;
            end else begin
              st_next.halves = 2'(st_reg.halves + 2'h1);
            end
          end else begin
            st_next.halves = 2'(st_reg.halves + 2'h1);
          end
          if (st_next.halves >= half_target && st_next.state == IFS_FLASH_ON) begin
            st_next.state = IFS_FLASH_OFF;
            st_next.ctrl.channel_on = 1'b0;
            st_next.halves = '0;
          end
        end
      end
      IFS_FLASH_OFF: begin
        // pin lags the channel by the synchroniser: judge it only at a crossing
        if (hi_rise && !s.out_low) begin
          st_next.state = IFS_IDLE;
          st_next.ctrl = '0;
        end else if (hi_rise) begin
          st_next.halves = 2'(st_reg.halves + 2'h1);
          if (2'(st_reg.halves + 2'h1) >= half_target) begin
            st_next.halves = '0;
            if (s.supply_ok) begin
              st_next.ctrl.supply_measure = 1'b1;
              st_next.state = IFS_FLASH_ON;
              st_next.ctrl.channel_on = 1'b1;
              st_next.first_diag = 1'b1;
            end else begin
              st_next.state = IFS_IDLE;
              st_next.ctrl = '0;
            end
          end
        end
      end
      IFS_THERMAL: begin
        st_next.ctrl.channel_on = 1'b0;
        if (!hot) begin
          if (st_reg.in_window && st_reg.win_cnt != '0) begin
            st_next.state = IFS_FLASH_ON;
            st_next.ctrl.channel_on = 1'b1;
            st_next.ctrl.supply_measure = 1'b1;
          end else begin
            st_next.state = IFS_LATCHED;
            st_next.ctrl.latched = 1'b1;
          end
        end else if (!st_reg.in_window || st_reg.win_cnt == '0) begin
          st_next.state = IFS_LATCHED;
          st_next.ctrl.latched = 1'b1;
        end
      end
      IFS_LATCHED: begin
        st_next.ctrl.channel_on = 1'b0;
        st_next.ctrl.charge = IFS_CHG_NONE;
        if (out_rise) begin
          st_next.state = IFS_IDLE;
          st_next.ctrl = '0;
        end
      end
      default: begin
        st_next.state = IFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ctrl_out = st_reg.ctrl;
  assign state_out = st_reg.state;

  sequence hot_seen_s;
    st_reg.state == IFS_FLASH_ON && hot;
  endsequence

  thermal_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    hot_seen_s |=> !ctrl_out.channel_on && state_out == IFS_THERMAL)
    else $error("temperature trip did not switch channel off");
  thermal_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_out == IFS_THERMAL |-> !ctrl_out.channel_on)
    else $error("channel on while overheated");
  latch_exit_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_out == IFS_LATCHED && !out_rise |=> state_out == IFS_LATCHED)
    else $error("latched state left without output rising");
  latch_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_out == IFS_LATCHED && out_rise |=> state_out == IFS_IDLE)
    else $error("output rising did not release latch");
  no_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_out == IFS_IDLE && !s.supply_ok |=> state_out == IFS_IDLE)
    else $error("started with supply below minimum");
  leak_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_out == IFS_IDLE && !s.leak_low |=> state_out == IFS_IDLE)
    else $error("activated with high output impedance");
  init_charge_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_out == IFS_INIT |-> ctrl_out.charge == IFS_CHG_INIT)
    else $error("init state without large charge current");
  switch_on_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(ctrl_out.channel_on) |-> ctrl_out.supply_measure)
    else $error("switch on without supply measurement");
  cap_stop_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s.cap_high && state_out inside {IFS_FLASH_ON, IFS_FLASH_OFF}
      |=> ctrl_out.charge == IFS_CHG_UNLOAD || state_out == IFS_IDLE)
    else $error("charge not stopped at high threshold");
  sample_ok_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ctrl_out.sense_sample |-> $past(!hard_fail))
    else $error("sense sampled during hard failure");

  // a clean diagnosis instant: first low crossing after switch-on, no hard failure
  sequence diag_s;
    st_reg.state == IFS_FLASH_ON && lo_rise && st_reg.first_diag && !hard_fail;
  endsequence

  sequence init_done_s;
    st_reg.state == IFS_INIT && s.out_low && s.supply_ok && s.leak_low
      && st_reg.init_cnt >= 32'(INIT_COUNT - 1);
  endsequence

  init_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
    init_done_s |=> state_out == IFS_FLASH_ON && ctrl_out.channel_on)
    else $error("channel not switched on after init time");
  diag_sample_a: assert property (@(posedge mclk) disable iff (!arst_n)
    diag_s |=> ctrl_out.sense_sample)
    else $error("no load measurement at diagnosis instant");
  underload_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    diag_s ##0 (!s.short_circuit && s.sense_low)
      |=> !ctrl_out.channel_on && ctrl_out.failure_mode && state_out == IFS_FLASH_OFF)
    else $error("underload did not switch off into failure mode");
  normal_keep_a: assert property (@(posedge mclk) disable iff (!arst_n)
    diag_s ##0 (!s.short_circuit && !s.sense_low && !st_reg.fail && st_reg.halves == 2'h0)
      |=> ctrl_out.channel_on && state_out == IFS_FLASH_ON)
    else $error("normal load did not keep channel on");
  short_latch_a: assert property (@(posedge mclk) disable iff (!arst_n)
    diag_s ##0 s.short_circuit |=> state_out == IFS_LATCHED && ctrl_out.latched)
    else $error("short circuit did not latch off");
  window_retry_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_reg.state == IFS_THERMAL && !hot && st_reg.in_window && st_reg.win_cnt != '0
      |=> state_out == IFS_FLASH_ON && ctrl_out.channel_on)
    else $error("no restart inside the first diagnosis window");
endmodule : ifs_sequencer

/* File: src/ifs_pkg.sv */
// package: shared types and constants of the flasher sequencer
package ifs_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned INIT_TIME_US = 100;
  localparam int unsigned INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int unsigned RESTART_WINDOW_MS = 130;
  localparam int unsigned RESTART_CYCLES = RESTART_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [1:0] PHASE_INIT_CYCLES = 2'h1;
  localparam logic [1:0] PHASE_FAIL_HALVES = 2'h1;
  localparam logic [1:0] PHASE_NORM_HALVES = 2'h2;

  typedef enum logic [2:0] {
    IFS_IDLE, IFS_INIT, IFS_FLASH_ON, IFS_FLASH_OFF, IFS_THERMAL, IFS_LATCHED
  } ifs_state_t;

  typedef enum logic [1:0] {IFS_CHG_NONE, IFS_CHG_INIT, IFS_CHG_LOAD, IFS_CHG_UNLOAD} ifs_charge_t;

  // analog comparator results from the front end
  typedef struct packed {
    logic out_low;
    logic cap_high;
    logic cap_low;
    logic sense_low;
    logic short_circuit;
    logic absolute_temp_trip;
    logic dynamic_temp_trip;
    logic current_limit;
    logic supply_ok;
    logic leak_low;
  } ifs_sense_t;

  // controls towards the analog front end
  typedef struct packed {
    logic channel_on;
    ifs_charge_t charge;
    logic sense_sample;
    logic supply_measure;
    logic failure_mode;
    logic latched;
  } ifs_ctrl_t;
endpackage : ifs_pkg

/* File: src/ifs_sync.sv */
// three-stage synchroniser with agreement filter
module ifs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } ifs_sync_state_t;

  ifs_sync_state_t st_reg;
  ifs_sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // only take a change once the last two stages agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.q;
endmodule : ifs_sync

/* File: tb/ifs_lamp_model.sv */
// far-side model: lamp load, selector switch and timing capacitor
module ifs_lamp_model
  import ifs_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire ifs_pkg::ifs_ctrl_t ctrl,
  input wire logic sw_closed,
  input wire logic supply_good,
  input wire logic rain,
  input wire logic underload,
  input wire logic shorted,
  input wire logic [1:0] hot,
  output ifs_pkg::ifs_sense_t sense
);
  logic [7:0] vcap;

  // capacitor voltage in coarse steps, init charge four times faster
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vcap <= 8'h00;
    end else begin
      case (ctrl.charge)
        IFS_CHG_INIT: vcap <= (vcap > 8'h4c) ? 8'h50 : vcap + 8'h04;
        IFS_CHG_LOAD: vcap <= (vcap < 8'h50) ? vcap + 8'h01 : vcap;
        IFS_CHG_UNLOAD: vcap <= (vcap > 8'h00) ? vcap - 8'h01 : vcap;
        default: vcap <= vcap;
      endcase
    end
  end

  always_comb begin
    // through the closed switch the lamp pulls the pin low unless the channel drives it, a short always does
    sense.out_low = sw_closed & (~ctrl.channel_on | shorted);
    sense.cap_high = (vcap >= 8'h40);
    sense.cap_low = (vcap <= 8'h28);
    sense.sense_low = ctrl.channel_on & underload;
    sense.short_circuit = ctrl.channel_on & shorted;
    sense.absolute_temp_trip = hot[0];
    sense.dynamic_temp_trip = hot[1];
    // limiting left out so the short stays visible to the diagnosis
    sense.current_limit = 1'b0;
    sense.supply_ok = supply_good;
    sense.leak_low = sw_closed & ~rain;
  end
endmodule : ifs_lamp_model

/* File: tb/ifs_sequencer_tb.sv */
// self-checking bench of the flasher sequencer
module ifs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ifs_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic sw_closed = 1'b0;
  logic supply_good = 1'b0;
  logic rain = 1'b0;
  logic underload = 1'b0;
  logic shorted = 1'b0;
  logic [1:0] hot = 2'h0;
  ifs_sense_t sense;
  ifs_ctrl_t ctrl;
  ifs_state_t state;
  ifs_state_t prev_state = IFS_IDLE;
  logic [6:0] exp_q[$];
  int n_errors = 0;
  int check_count = 0;

  always #5 mclk = ~mclk;

  ifs_sequencer #(.INIT_COUNT(8), .RESTART_COUNT(200)) ifs_sequencer_inst (
    .mclk(mclk), .arst_n(arst_n), .sense_in(sense), .ctrl_out(ctrl), .state_out(state));

  ifs_lamp_model ifs_lamp_model_inst (
    .mclk(mclk), .arst_n(arst_n), .ctrl(ctrl), .sw_closed(sw_closed),
    .supply_good(supply_good), .rain(rain), .underload(underload),
    .shorted(shorted), .hot(hot), .sense(sense));

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // each state change while a note is pending consumes the oldest note
  always @(posedge mclk) begin
    if (arst_n && state !== prev_state && exp_q.size() > 0) begin
      check("state_change", 10'({state, ctrl.channel_on, ctrl.failure_mode, ctrl.latched,
        ctrl.supply_measure}), 10'(exp_q.pop_front()));
      if (state === IFS_INIT) begin
        check("init_charge", 10'(ctrl.charge), 10'(IFS_CHG_INIT));
      end
    end
    prev_state <= state;
  end

  task automatic do_reset(input logic sup, input logic wet);
    @(posedge mclk);
    arst_n <= 1'b0;
    sw_closed <= 1'b0;
    supply_good <= sup;
    rain <= wet;
    underload <= 1'b0;
    shorted <= 1'b0;
    hot <= 2'h0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    exp_q.delete();
    repeat (6) @(posedge mclk);
  endtask : do_reset

  task automatic start_flash();
    repeat ($urandom_range(8, 1)) @(posedge mclk);
    sw_closed <= 1'b1;
    exp_q.push_back({IFS_INIT, 4'h0});
    exp_q.push_back({IFS_FLASH_ON, 4'h9});
  endtask : start_flash

  // bounded wait until every note has been matched
  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge mclk);
    check("pending_notes", 10'(exp_q.size()), 10'h000);
  endtask : drain

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'h29ff));
    do_reset(1'b0, 1'b0);
    check("reset_outputs", {state, ctrl}, 10'h000);
    sw_closed <= 1'b1;
    repeat (40) @(posedge mclk);
    check("low_supply", 10'(state), 10'(IFS_IDLE));
    do_reset(1'b1, 1'b1);
    sw_closed <= 1'b1;
    repeat (40) @(posedge mclk);
    check("leaky_output", 10'(state), 10'(IFS_IDLE));
    do_reset(1'b1, 1'b0);
    start_flash();
    exp_q.push_back({IFS_FLASH_OFF, 4'h0});
    exp_q.push_back({IFS_FLASH_ON, 4'h9});
    drain();
    do_reset(1'b1, 1'b0);
    underload <= 1'b1;
    start_flash();
    exp_q.push_back({IFS_FLASH_OFF, 4'h4});
    exp_q.push_back({IFS_FLASH_ON, 4'hd});
    drain();
    do_reset(1'b1, 1'b0);
    shorted <= 1'b1;
    start_flash();
    exp_q.push_back({IFS_LATCHED, 4'h2});
    drain();
    sw_closed <= 1'b0;
    exp_q.push_back({IFS_IDLE, 4'h0});
    drain();
    // short trip recovers inside the window, a long one outlives it
    for (int i = 0; i < 2; i++) begin
      do_reset(1'b1, 1'b0);
      start_flash();
      drain();
      hot <= 2'(1 << i);
      exp_q.push_back({IFS_THERMAL, 4'h0});
      if (i == 1) begin
        exp_q.push_back({IFS_LATCHED, 4'h2});
      end else begin
        exp_q.push_back({IFS_FLASH_ON, 4'h9});
      end
      repeat ((i == 1) ? 300 : 8) @(posedge mclk);
      hot <= 2'h0;
      drain();
    end
    conclude();
  end
endmodule : ifs_sequencer_tb
